/* pkg/flag_host_map.svh */
// Purpose: constants for the semaphore flag host controller
// Assumes: 200 MHz system clock
// Notes: pin timing figures are plain defaults, not device figures
`ifndef FLAG_HOST_MAP_SVH
`define FLAG_HOST_MAP_SVH

`define FLAG_COUNT 8
`define FLAG_INDEX_W 3
`define DATA_W 36
`define ADDR_W 17
`define FLAG_BIT 0
// pin phase length in ns and the derived cycle count at 5 ns per cycle
`define PHASE_NS 20
`define CLK_NS 5
`define PHASE_CYC ((`PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`define PHASE_CNT_W 4

`endif

/* pkg/flag_host_pkg.sv */
// Purpose: types for the semaphore flag host controller
// Assumes: flag_host_map.svh supplies widths
// Notes: none
`default_nettype none
`include "flag_host_map.svh"
package flag_host_pkg;
  typedef enum logic [1:0] {
    CMD_ACQUIRE = 2'b00, // write zero then read back
    CMD_RELEASE = 2'b01, // write one
    CMD_POLL = 2'b10, // read only
    CMD_INIT = 2'b11 // write one to every flag
  } cmd_t;

  typedef struct packed {
    cmd_t cmd;
    logic [`FLAG_INDEX_W-1:0] index;
  } req_t;

  typedef struct packed {
    logic owned; // flag read back as zero
    logic [`FLAG_INDEX_W-1:0] index;
  } resp_t;

  typedef struct packed {
    logic flag_space_select_n;
    logic chip_enable_n;
    logic write_n;
    logic output_enable_n;
    logic lane_zero_enable_n;
    logic [`ADDR_W-1:0] addr;
  } pins_t;
endpackage : flag_host_pkg
`default_nettype wire

/* src/phase_timer.sv */
// Purpose: counts one pin phase and pulses when it ends
// Assumes: start is a one-cycle pulse
// Notes: restart while busy reloads the count
`default_nettype none
`include "flag_host_map.svh"
module phase_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  output logic done
);
  logic [`PHASE_CNT_W-1:0] cnt_reg;
  logic busy_reg;

  // count down one phase, done pulses on the last cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= `PHASE_CNT_W'(`PHASE_CYC - 1);
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // done must not look at start: start is built from done, which would close a loop
  assign done = busy_reg && (cnt_reg == '0);
endmodule : phase_timer
`default_nettype wire

/* src/flag_host.sv */
// Purpose: drives one port of a dual-port memory's semaphore flags
// Assumes: one clock, synchronous reset, device data sampled through two flops
// Notes: each access is setup, strobe and recovery phases of equal length
// Summary of operation
// - zero requests a flag, one releases
// - select flag space, use static-memory controls
// - drop select between polling reads
// - acquire by write then read back
// - failed request: keep reading or release
// - software writes one to all flags first
// - chip enable held high during flag access
`default_nettype none
`include "flag_host_map.svh"
module flag_host (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire flag_host_pkg::req_t req,
  output logic resp_valid,
  output flag_host_pkg::resp_t resp,
  output flag_host_pkg::pins_t pins,
  output logic [`DATA_W-1:0] data_out,
  output logic [`DATA_W-1:0] data_oe,
  input wire logic [`DATA_W-1:0] data_in
);
  import flag_host_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_RECOVER = 3'b011,
    ST_RESP = 3'b100
  } state_t;

  state_t state_reg;
  req_t cur_reg;
  logic is_read_reg;
  logic wr_val_reg;
  logic [`FLAG_INDEX_W-1:0] idx_reg;
  logic owned_reg;
  logic [`DATA_W-1:0] din_meta_reg;
  logic [`DATA_W-1:0] din_sync_reg;
  logic phase_start;
  logic phase_done;
  logic last_init;

  phase_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(phase_start),
    .done(phase_done)
  );

  // ----------------------------------------
  // data input synchroniser
  // ----------------------------------------
  // two flops before any logic reads the device data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end else begin
      din_meta_reg <= data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  assign req_ready = (state_reg == ST_IDLE);
  assign last_init = (idx_reg == `FLAG_INDEX_W'(`FLAG_COUNT - 1));

  // a phase starts on accept and on every phase end except the last
  assign phase_start = (state_reg == ST_IDLE && req_valid) ||
                       (phase_done && state_reg != ST_RECOVER) ||
                       (phase_done && state_reg == ST_RECOVER &&
                        ((cur_reg.cmd == CMD_ACQUIRE && !is_read_reg) ||
                         (cur_reg.cmd == CMD_INIT && !last_init)));

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  // acquire is a write of zero then a read back, never read first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cur_reg <= '0;
      is_read_reg <= 1'b0;
      wr_val_reg <= 1'b1;
      idx_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (req_valid) begin
            cur_reg <= req;
            idx_reg <= (req.cmd == CMD_INIT) ? '0 : req.index;
            is_read_reg <= (req.cmd == CMD_POLL);
            wr_val_reg <= (req.cmd != CMD_ACQUIRE);
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (phase_done) begin
            state_reg <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (phase_done) begin
            state_reg <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          // select deasserted here so each poll relatches the output
          if (phase_done) begin
            if (cur_reg.cmd == CMD_ACQUIRE && !is_read_reg) begin
              is_read_reg <= 1'b1;
              state_reg <= ST_SETUP;
            end else if (cur_reg.cmd == CMD_INIT && !last_init) begin
              idx_reg <= idx_reg + 1'b1;
              state_reg <= ST_SETUP;
            end else begin
              state_reg <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read capture
  // ----------------------------------------
  // sample the replicated flag on bit zero at the end of the read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      owned_reg <= 1'b0;
    end else if (state_reg == ST_STROBE && phase_done && is_read_reg) begin
      owned_reg <= ~din_sync_reg[`FLAG_BIT];
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // registered pins; chip enable stays high for every flag access
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pins.flag_space_select_n <= 1'b1;
      pins.chip_enable_n <= 1'b1;
      pins.write_n <= 1'b1;
      pins.output_enable_n <= 1'b1;
      pins.lane_zero_enable_n <= 1'b1;
      pins.addr <= '0;
      data_out <= '0;
      data_oe <= '0;
    end else begin
      pins.chip_enable_n <= 1'b1;
      pins.addr <= {{(`ADDR_W - `FLAG_INDEX_W){1'b0}}, idx_reg};
      data_out <= {{(`DATA_W - 1){1'b0}}, wr_val_reg};
      // low from the end of setup to the end of strobe, exactly one phase long
      if ((state_reg == ST_SETUP && phase_done) || (state_reg == ST_STROBE && !phase_done)) begin
        // strobe phase: select low, write or output enable asserted
        pins.flag_space_select_n <= 1'b0;
        pins.lane_zero_enable_n <= 1'b0;
        pins.write_n <= is_read_reg;
        pins.output_enable_n <= ~is_read_reg;
        data_oe <= {`DATA_W{~is_read_reg}};
      end else begin
        // setup and recovery: all strobes high, select off between reads
        pins.flag_space_select_n <= 1'b1;
        pins.lane_zero_enable_n <= 1'b1;
        pins.write_n <= 1'b1;
        pins.output_enable_n <= 1'b1;
        data_oe <= (state_reg == ST_SETUP || state_reg == ST_STROBE) ? {`DATA_W{~is_read_reg}} : '0;
      end
    end
  end

  // ----------------------------------------
  // response
  // ----------------------------------------
  // one-cycle response; owned only meaningful for acquire and poll
  assign resp_valid = (state_reg == ST_RESP);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp <= '0;
    end else if (state_reg == ST_RECOVER && phase_done) begin
      resp.owned <= (cur_reg.cmd == CMD_RELEASE || cur_reg.cmd == CMD_INIT) ? 1'b0 : owned_reg;
      resp.index <= idx_reg;
    end
  end
endmodule : flag_host
`default_nettype wire

/* testbench/flag_host_asserts.sv */
// Purpose: pin checks for flag_host
// Assumes: four-cycle phases
// Notes: bind at foot
`default_nettype none
`include "flag_host_map.svh"
module flag_host_asserts import flag_host_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire req_t req,
  input wire logic resp_valid,
  input wire pins_t pins,
  input wire logic [`DATA_W-1:0] data_out,
  input wire logic [`DATA_W-1:0] data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic sel_n;
  // strobe decode
  assign sel_n = pins.flag_space_select_n;
  sequence wr_s; !sel_n && !pins.write_n; endsequence
  sequence rd_s; !sel_n && !pins.output_enable_n; endsequence
  ce_high_a: assert property (pins.chip_enable_n) else $error("ce low");
  write_lsb_a: assert property (wr_s |-> data_oe[0] && data_out[`DATA_W-1:1] == '0) else $error("bad write");
  addr_hold_a: assert property (!sel_n |-> $stable(pins.addr)) else $error("addr moved");
  strobe_len_a: assert property ($fell(sel_n) |-> (!sel_n)[*4] ##1 sel_n) else $error("strobe len");
  take_strobe_a: assert property (req_valid && req_ready |-> ##[1:8] $fell(sel_n)) else $error("no strobe");
  read_quiet_a: assert property (rd_s |-> pins.write_n && data_oe == '0) else $error("drive in read");
  recover_a: assert property ($rose(sel_n) |-> sel_n[*4]) else $error("short gap");
  acquire_order_a: assert property (req_valid && req_ready && req.cmd == CMD_ACQUIRE |->
    ##[1:10] wr_s ##[1:16] rd_s) else $error("acq order");
  resp_idle_a: assert property (resp_valid |-> sel_n && data_oe == '0) else $error("busy answer");
endmodule : flag_host_asserts
bind flag_host flag_host_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .resp_valid(resp_valid), .pins(pins), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

/* testbench/flag_device_model.sv */
// Purpose: flag device, left port on pins
// Assumes: right port worked by tasks
// Notes: a tie goes to the left
`default_nettype none
`include "flag_host_map.svh"
module flag_device_model import flag_host_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire pins_t pins,
  input wire logic [`DATA_W-1:0] data_out,
  output logic [`DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lreq_reg;
  logic [7:0] rreq_reg;
  logic [1:0] own_reg [8]; // 0 free, 1 left, 2 right
  logic lat_reg;
  logic rd_was_reg;
  logic rd_on;
  logic [2:0] a;
  // holder of a flag after a latch changes
  function automatic logic [1:0] grant(input logic [1:0] o, input logic l, input logic r);
    if ((o == 2'h1 && !l) || (o == 2'h2 && !r)) return o;
    if (o == 2'h1) return r ? 2'h0 : 2'h2;
    if (o == 2'h2) return l ? 2'h0 : 2'h1;
    return !l ? 2'h1 : (!r ? 2'h2 : 2'h0);
  endfunction : grant
  task automatic r_write(input int i, input logic v);
    rreq_reg[i] = v;
    own_reg[i] = grant(own_reg[i], lreq_reg[i], v);
  endtask : r_write
  function automatic logic right_view(input int i);
    return own_reg[i] != 2'h2;
  endfunction : right_view
  // left port decode, released bus shows the inverse
  assign rd_on = !pins.flag_space_select_n && !pins.lane_zero_enable_n && !pins.output_enable_n;
  assign a = pins.addr[2:0];
  assign data_in = rd_on ? {`DATA_W{lat_reg}} : ~{`DATA_W{lat_reg}};
  // left writes and read latch
  always @(posedge clk_sys) begin
    if (rst) begin
      lreq_reg = 8'hff;
      rreq_reg = 8'hff;
      own_reg = '{default: 2'h0};
      rd_was_reg = 1'b0;
      lat_reg = 1'b1;
    end else begin
      if (!pins.flag_space_select_n && !pins.write_n && !pins.lane_zero_enable_n) begin
        lreq_reg[a] = data_out[0];
        own_reg[a] = grant(own_reg[a], data_out[0], rreq_reg[a]);
      end
      if (rd_on && !rd_was_reg) lat_reg = own_reg[a] != 2'h1;
      rd_was_reg = rd_on;
    end
  end
endmodule : flag_device_model
`default_nettype wire

/* testbench/dual_port_semaphore_flags_tb_top.sv */
// Purpose: directed test of flag_host
// Assumes: right port set through the model
// Notes: none
`default_nettype none
`include "flag_host_map.svh"
module dual_port_semaphore_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flag_host_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  req_t req = '0;
  logic req_ready;
  logic resp_valid;
  resp_t resp;
  pins_t pins;
  logic [`DATA_W-1:0] data_out;
  logic [`DATA_W-1:0] data_oe;
  logic [`DATA_W-1:0] data_in;
  int error_cnt = 0;
  int compares = 0;
  flag_host dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .resp_valid(resp_valid), .resp(resp), .pins(pins), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  flag_device_model model (.clk_sys(clk_sys), .rst(rst), .pins(pins), .data_out(data_out), .data_in(data_in));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // one request, then wait for and judge its answer
  task automatic run(input cmd_t c, input logic [2:0] i, input logic own);
    int n;
    logic [2:0] ei;
    n = 0;
    // init walks every flag and answers with the last one it wrote
    ei = (c == CMD_INIT) ? 3'(`FLAG_COUNT - 1) : i;
    req_valid <= 1'b1;
    req <= '{cmd: c, index: i};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (resp_valid !== 1'b1 && n < 200);
    chk(resp_valid, 1'b1, "no answer");
    chk(resp.owned, own, "owned");
    chk(resp.index == ei, 1'b1, "index");
    @(posedge clk_sys);
  endtask : run
  task automatic rw(input int i, input logic v);
    @(negedge clk_sys);
    model.r_write(i, v);
    @(posedge clk_sys);
  endtask : rw
  task automatic t_free();
    run(CMD_ACQUIRE, 3'h3, 1'b1);
    chk(model.right_view(3), 1'b1, "right view");
    run(CMD_POLL, 3'h3, 1'b1);
  endtask : t_free
  task automatic t_init();
    for (int i = 0; i < 8; i++) begin
      run(CMD_ACQUIRE, i[2:0], 1'b1);
    end
    run(CMD_INIT, 3'h0, 1'b0);
    chk(model.lreq_reg == 8'hff, 1'b1, "not freed");
    run(CMD_POLL, 3'h7, 1'b0);
  endtask : t_init
  task automatic t_block();
    rw(5, 1'b0);
    run(CMD_ACQUIRE, 3'h5, 1'b0);
    chk(model.lreq_reg[5], 1'b0, "request lost");
    rw(5, 1'b1);
    run(CMD_POLL, 3'h5, 1'b1);
    chk(model.right_view(5), 1'b1, "right kept");
    run(CMD_RELEASE, 3'h5, 1'b0);
    rw(5, 1'b0);
    chk(model.right_view(5), 1'b0, "not free");
    run(CMD_ACQUIRE, 3'h5, 1'b0);
    run(CMD_RELEASE, 3'h5, 1'b0);
    rw(5, 1'b1);
    run(CMD_POLL, 3'h5, 1'b0);
  endtask : t_block
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_free();
    t_init();
    t_block();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
